// ==== design/adc_comparator.v ====
// Digital comparator watching ADC results, with AXI4-Lite registers.
// Assumes results arrive from logic on aclk as one-cycle valid strobes.
`timescale 1ns/1ps
// Summary of operation
// - The matched channel field holds the binary input number, 0 to 21.
// - Codes 22 to 31 are never reported as a detected channel.
// - Results are judged only while comparator on is set; clearing it drops the flag.
// - With interrupt on match set each event raises the ADC interrupt, else none.
// - The between mode bit makes a result between the thresholds an event.
// - Each threshold mode bit enables its own condition; any mix is allowed.
// - Channels 0 to 15 are compared only when their low enable bit is set.
// - Channels 16 to 21 use the six low bits of the high enable register.
// - Bits 15 to 6 of the high enable register always read zero.
module adc_comparator (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    // AXI4-Lite write address
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Conversion results
    input  wire        result_valid,
    input  wire [4:0]  result_channel,
    input  wire [11:0] result_data,
    // Interrupts
    output wire        adc_interrupt,
    output wire        irq
);
`include "adc_defines.vh"

    // Registers
    reg  [7:0]  ctrl_q;
    reg         match_q;
    reg  [4:0]  matched_channel_q;
    reg  [15:0] channel_enable_low_bits_q;
    reg  [5:0]  channel_enable_high_bits_q;
    reg  [11:0] lower_threshold_q;
    reg  [11:0] upper_threshold_q;
    reg  [1:0]  irq_status_q;
    reg  [1:0]  irq_mask_q;
    reg         int_pulse_q;
    reg  [4:0]  awaddr_q;
    reg         aw_held_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         w_held_q;
    reg         res_valid_q;
    reg  [4:0]  res_chan_q;
    reg  [11:0] res_data_q;

    wire        comparator_on    = ctrl_q[`ADC_CTL_ON];
    wire        interrupt_on_match = ctrl_q[`ADC_CTL_INT_EN];
    wire [21:0] chan_en;
    wire        hit;
    wire        chan_ok;
    wire        event_now;

    // Channel enable vector
    genvar g;
    generate
        for (g = 0; g < `ADC_NUM_CH; g = g + 1) begin : g_en
            if (g < `ADC_LOW_EN_W) begin : g_lo
                assign chan_en[g] = channel_enable_low_bits_q[g];
            end else begin : g_hi
                assign chan_en[g] =
                    channel_enable_high_bits_q[g - `ADC_LOW_EN_W];
            end
        end
    endgenerate

    // Only channels 0 to 21 take part
    assign chan_ok = (res_chan_q <= `ADC_CH_LAST) && chan_en[res_chan_q];

    adc_event_detect u_detect (
        .result          (res_data_q),
        .lower_threshold (lower_threshold_q),
        .upper_threshold (upper_threshold_q),
        .mode_bits       (ctrl_q[4:0]),
        .hit             (hit)
    );

    // Evaluate only while on
    assign event_now = res_valid_q & comparator_on & chan_ok & hit;

    // AXI handshakes
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    // Readies drop while frozen so no beat is lost
    assign s_axi_awready = clk_en & ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready  = clk_en & ~w_held_q & ~s_axi_bvalid;
    assign s_axi_arready = clk_en & ~s_axi_rvalid;
    wire ar_take = s_axi_arvalid & s_axi_arready;

    wire        wr_go   = (aw_held_q | aw_take) & (w_held_q | w_take);
    wire [4:0]  wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    wire        wr_page = wr_addr[4];
    wire [3:0]  wr_off  = {wr_addr[3:2], 2'b00};
    wire        rd_page = s_axi_araddr[4];
    wire [3:0]  rd_off  = {s_axi_araddr[3:2], 2'b00};

    // Write decode
    wire wr_ctl = wr_go && wr_page == `ADC_ADDR_PAGE_LO
                  && wr_off == `ADC_REG_CONTROL;
    wire wr_enl = wr_go && wr_page == `ADC_ADDR_PAGE_LO
                  && wr_off == `ADC_REG_ENABLE_LOW;
    wire wr_enh = wr_go && wr_page == `ADC_ADDR_PAGE_LO
                  && wr_off == `ADC_REG_ENABLE_HIGH;
    wire wr_thl = wr_go && wr_page == `ADC_ADDR_PAGE_LO
                  && wr_off == `ADC_REG_THRESH_LOW;
    wire wr_thh = wr_go && wr_page == `ADC_ADDR_PAGE_HI
                  && wr_off == `ADC_REG_THRESH_HIGH;
    wire wr_msk = wr_go && wr_page == `ADC_ADDR_PAGE_HI
                  && wr_off == `ADC_REG_IRQ_MASK;
    wire wr_sts = wr_go && wr_page == `ADC_ADDR_PAGE_HI
                  && wr_off == `ADC_REG_IRQ_STATUS;
    wire wr_ok  = wr_ctl | wr_enl | wr_enh | wr_thl | wr_thh | wr_msk
                  | wr_sts;

    // Read decode
    wire rd_ctl = ar_take && rd_page == `ADC_ADDR_PAGE_LO
                  && rd_off == `ADC_REG_CONTROL;
    wire rd_sts = ar_take && rd_page == `ADC_ADDR_PAGE_HI
                  && rd_off == `ADC_REG_IRQ_STATUS;

    // Read data mux
    reg [31:0] rd_word;
    reg        rd_err;
    always @* begin
        rd_word = `ADC_ZERO32;
        rd_err  = 1'b0;
        if (rd_page == `ADC_ADDR_PAGE_LO) begin
            case (rd_off)
                `ADC_REG_CONTROL:
                    rd_word = {19'h00000, matched_channel_q, ctrl_q[7:6],
                               match_q, ctrl_q[4:0]};
                `ADC_REG_ENABLE_LOW:
                    rd_word = {16'h0000, channel_enable_low_bits_q};
                `ADC_REG_ENABLE_HIGH:
                    // Upper bits read zero
                    rd_word = {26'h0000000, channel_enable_high_bits_q};
                `ADC_REG_THRESH_LOW:
                    rd_word = {20'h00000, lower_threshold_q};
                default:
                    rd_err = 1'b1;
            endcase
        end else begin
            case (rd_off)
                `ADC_REG_THRESH_HIGH:
                    rd_word = {20'h00000, upper_threshold_q};
                `ADC_REG_IRQ_STATUS:
                    rd_word = {30'h00000000, irq_status_q};
                `ADC_REG_IRQ_MASK:
                    rd_word = {30'h00000000, irq_mask_q};
                default:
                    rd_err = 1'b1;
            endcase
        end
    end

    // Flag and interrupt qualifiers
    wire ctl_off_wr = wr_ctl & wr_strb[0] & ~wr_data[`ADC_CTL_ON];
    wire int_event  = event_now & interrupt_on_match;

    // Result capture
    always @(posedge aclk) begin
        if (!aresetn) begin
            res_valid_q <= 1'b0;
            res_chan_q  <= `ADC_ZERO5;
            res_data_q  <= `ADC_ZERO12;
        end else if (clk_en) begin
            res_valid_q <= result_valid;
            res_chan_q  <= result_channel;
            res_data_q  <= result_data;
        end
    end

    // Bus slave handshake state
    always @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q     <= `ADC_ZERO5;
            aw_held_q    <= 1'b0;
            wdata_q      <= `ADC_ZERO32;
            wstrb_q      <= `ADC_ZERO4;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ADC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `ADC_RESP_OKAY;
            s_axi_rdata  <= `ADC_ZERO32;
        end else if (clk_en) begin
            // Write channel capture
            if (aw_take && !wr_go) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (w_take && !wr_go) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Read channel
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_err ? `ADC_RESP_SLVERR : `ADC_RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Configuration registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q                     <= `ADC_ZERO8;
            channel_enable_low_bits_q  <= `ADC_ZERO16;
            channel_enable_high_bits_q <= `ADC_ZERO6;
            lower_threshold_q          <= `ADC_ZERO12;
            upper_threshold_q          <= `ADC_ZERO12;
            irq_mask_q                 <= `ADC_ZERO2;
        end else if (clk_en) begin
            // Status bit of control is never written
            if (wr_ctl && wr_strb[0])
                ctrl_q <= wr_data[7:0] & `ADC_CTL_WMASK;
            if (wr_enl && wr_strb[0])
                channel_enable_low_bits_q[7:0] <= wr_data[7:0];
            if (wr_enl && wr_strb[1])
                channel_enable_low_bits_q[15:8] <= wr_data[15:8];
            if (wr_enh && wr_strb[0])
                channel_enable_high_bits_q <= wr_data[5:0];
            if (wr_thl && wr_strb[0])
                lower_threshold_q[7:0] <= wr_data[7:0];
            if (wr_thl && wr_strb[1])
                lower_threshold_q[11:8] <= wr_data[11:8];
            if (wr_thh && wr_strb[0])
                upper_threshold_q[7:0] <= wr_data[7:0];
            if (wr_thh && wr_strb[1])
                upper_threshold_q[11:8] <= wr_data[11:8];
            if (wr_msk && wr_strb[0])
                irq_mask_q <= wr_data[1:0];
        end
    end

    // Match flag, channel and interrupt state
    always @(posedge aclk) begin
        if (!aresetn) begin
            match_q           <= 1'b0;
            matched_channel_q <= `ADC_ZERO5;
            int_pulse_q       <= 1'b0;
            irq_status_q      <= `ADC_ZERO2;
        end else if (clk_en) begin
            // Set wins over read or disable clear
            if (event_now) begin
                match_q           <= 1'b1;
                matched_channel_q <= res_chan_q;
            end else if (rd_ctl || !comparator_on || ctl_off_wr) begin
                match_q <= 1'b0;
            end
            // Common interrupt strobe per event
            int_pulse_q <= int_event;
            // Sticky status, cleared by its read, set wins
            irq_status_q <= (rd_sts ? `ADC_ZERO2 : irq_status_q)
                            | {int_event, event_now};
        end
    end

    assign adc_interrupt = int_pulse_q;
    assign irq = |(irq_status_q & irq_mask_q);

endmodule

// ==== design/adc_defines.vh ====
// Constants for the ADC result digital comparator.
// Assumes inclusion by design files only; definitions only.
`ifndef ADC_DEFINES_VH
`define ADC_DEFINES_VH

// Register byte addresses
`define ADC_REG_CONTROL      4'h0
`define ADC_REG_ENABLE_LOW   4'h4
`define ADC_REG_ENABLE_HIGH  4'h8
`define ADC_REG_THRESH_LOW   4'hC
`define ADC_REG_THRESH_HIGH  4'h0
`define ADC_REG_IRQ_STATUS   4'h4
`define ADC_REG_IRQ_MASK     4'h8
`define ADC_ADDR_PAGE_LO     1'h0
`define ADC_ADDR_PAGE_HI     1'h1

// Control field positions
`define ADC_CTL_BELOW_LO     0
`define ADC_CTL_ABOVE_LO     1
`define ADC_CTL_BELOW_HI     2
`define ADC_CTL_ABOVE_HI     3
`define ADC_CTL_BETWEEN      4
`define ADC_CTL_STAT         5
`define ADC_CTL_INT_EN       6
`define ADC_CTL_ON           7
`define ADC_CTL_CHAN_LSB     8
`define ADC_CTL_WMASK        8'hDF

// Widths and limits
`define ADC_NUM_CH           22
`define ADC_CH_W             5
`define ADC_CH_LAST          5'h15
`define ADC_RES_W            12
`define ADC_HIGH_EN_W        6
`define ADC_LOW_EN_W         16

// Reset values and misc
`define ADC_ZERO16           16'h0000
`define ADC_ZERO32           32'h00000000
`define ADC_ZERO12           12'h000
`define ADC_ZERO5            5'h00
`define ADC_ZERO8            8'h00
`define ADC_ZERO6            6'h00
`define ADC_ZERO2            2'h0
`define ADC_ZERO4            4'h0
`define ADC_RESP_OKAY        2'h0
`define ADC_RESP_SLVERR      2'h2

`endif

// ==== design/adc_event_detect.v ====
// Threshold evaluation of one conversion result.
// Assumes result and thresholds are stable in the cycle they are sampled.
`timescale 1ns/1ps
module adc_event_detect (
    // Result and thresholds
    input  wire [11:0] result,
    input  wire [11:0] lower_threshold,
    input  wire [11:0] upper_threshold,
    // Mode selects
    input  wire [4:0]  mode_bits,
    // Detection
    output wire        hit
);
`include "adc_defines.vh"

    wire ge_hi = (result >= upper_threshold);
    wire ge_lo = (result >= lower_threshold);
    wire [4:0] cond;

    // Per-mode condition
    assign cond[`ADC_CTL_ABOVE_HI] = ge_hi;
    assign cond[`ADC_CTL_BELOW_HI] = ~ge_hi;
    assign cond[`ADC_CTL_ABOVE_LO] = ge_lo;
    assign cond[`ADC_CTL_BELOW_LO] = ~ge_lo;
    assign cond[`ADC_CTL_BETWEEN]  = ge_lo & ~ge_hi;

    // Any enabled mode may fire
    assign hit = |(cond & mode_bits);

endmodule

// ==== testbench/adc_cmp_chk.sv ====
// Checker for the ADC comparator: port relations over time.
// Assumes binding to adc_comparator; sees only its ports.
`timescale 1ns/1ps
module adc_cmp_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [4:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Results and interrupt
    input wire logic        result_valid,
    input wire logic [4:0]  result_channel,
    input wire logic        adc_interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !clk_en);
    // Address of the read in flight
    logic [4:0] ra_q;
    always @(posedge aclk) begin
        if (!aresetn)
            ra_q <= 5'h00;
        else if (s_axi_arvalid && s_axi_arready)
            ra_q <= s_axi_araddr;
    end
    int_cause_a: assert property (
        adc_interrupt |-> $past(result_valid, 2)
        && $past(result_channel, 2) <= 5'h15) else $error("stray interrupt");
    res_ignore_a: assert property (
        result_valid && result_channel > 5'h15 |-> ##2 !adc_interrupt)
        else $error("reserved channel matched");
    high_zero_a: assert property (s_axi_rvalid && ra_q == 5'h08
        |-> s_axi_rdata[31:6] == 26'h0) else $error("high enable bits set");
    chan_code_a: assert property (s_axi_rvalid && ra_q == 5'h00
        |-> s_axi_rdata[12:8] <= 5'h15) else $error("bad channel code");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("no write response");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("no read response");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
endmodule
bind adc_comparator adc_cmp_chk u_chk (.*);

// ==== testbench/adc_res_src.sv ====
// Model of the conversion result path feeding the comparator.
// Assumes the caller enters send just after a rising edge of aclk.
`timescale 1ns/1ps
module adc_res_src (
    // Clock
    input wire logic         aclk,
    // Result strobe
    output logic             result_valid,
    output logic [4:0]       result_channel,
    output logic [11:0]      result_data
);
    initial begin
        result_valid = 1'h0;
        result_channel = 5'h00;
        result_data = 12'h000;
    end
    // One-cycle strobe, then the lines show the inverse value
    task send(input logic [4:0] c, input logic [11:0] v);
        @(posedge aclk);
        result_valid <= 1'h1;
        result_channel <= c;
        result_data <= v;
        @(posedge aclk);
        result_valid <= 1'h0;
        result_channel <= ~c;
        result_data <= ~v;
    endtask
endmodule

// ==== testbench/adc_result_digital_comparator_tb_top.sv ====
// Self-checking bench for the ADC comparator and its register bus.
// Assumes adc_comparator and the result source model are compiled first.
`timescale 1ns/1ps
module adc_result_digital_comparator_tb_top;
    logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
    logic s_axi_rvalid, adc_interrupt, irq, result_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [4:0] result_channel;
    logic [11:0] result_data;
    logic [3:0] tab [5] = '{4'h1, 4'hE, 4'h7, 4'h8, 4'h6};
    logic [11:0] vals [4] = '{12'h0FF, 12'h100, 12'h1FF, 12'h200};
    int fails = 0, comparisons = 0, ints = 0;
    adc_comparator u_adc_comparator (.*);
    adc_res_src u_adc_res_src (.*);
    always #10 aclk = ~aclk;
    always @(posedge aclk) if (adc_interrupt === 1'h1) ints <= ints + 1;
    task close_out;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // One register access; w selects write, otherwise read
    task bus(input bit w, input logic [4:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta) begin
                s_axi_awvalid <= 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (tw) s_axi_wvalid <= 1'h0;
            if (tb) begin
                s_axi_bready <= 1'h0;
                s_axi_rready <= 1'h0;
                return;
            end
        end
        fails++;
        close_out;
    endtask
    // Send a result, then read control and judge flag, channel, pulse
    task ev(input logic [4:0] c, input logic [11:0] v, input bit h, input bit e);
        int n0;
        n0 = ints;
        u_adc_res_src.send(c, v);
        repeat (4) @(posedge aclk);
        bus(0, 5'h00, 32'h0);
        chk(q[5], h);
        if (h) chk(q[12:8], c);
        chk(ints - n0, h && e);
    endtask
    task regs_scn;
        bus(0, 5'h00, 32'h0);
        chk(q, 32'h0);
        bus(1, 5'h08, 32'hFFFFFFFF);
        chk(r, 32'h0);
        bus(0, 5'h08, 32'h0);
        chk(q, 32'h3F);
        bus(0, 5'h1C, 32'h0);
        chk(r, 32'h2);
        bus(1, 5'h1C, 32'h1);
        chk(r, 32'h2);
    endtask
    task modes_scn;
        bus(1, 5'h04, 32'hFFFF);
        bus(1, 5'h0C, 32'h100);
        bus(1, 5'h10, 32'h200);
        for (int m = 0; m < 5; m++) begin
            bus(1, 5'h00, 32'hC0 | (32'h1 << m));
            for (int i = 0; i < 4; i++)
                ev(5'(m * 4 + i), vals[i], tab[m][i], 1);
        end
        bus(1, 5'h00, 32'hC9);
        ev(5'h02, 12'h0FF, 1, 1);
        ev(5'h02, 12'h1FF, 0, 1);
        ev(5'h02, 12'h200, 1, 1);
    endtask
    task enable_scn;
        bus(1, 5'h04, 32'h0008);
        bus(1, 5'h08, 32'h20);
        bus(1, 5'h00, 32'hC2);
        ev(5'h15, 12'h200, 1, 1);
        ev(5'h14, 12'h200, 0, 1);
        ev(5'h03, 12'h200, 1, 1);
        ev(5'h04, 12'h200, 0, 1);
        ev(5'h16, 12'h200, 0, 1);
        ev(5'h1F, 12'h200, 0, 1);
    endtask
    task irq_scn;
        bus(1, 5'h00, 32'h82);
        ev(5'h03, 12'h200, 1, 0);
        bus(0, 5'h14, 32'h0);
        bus(1, 5'h18, 32'h1);
        ev(5'h03, 12'h200, 1, 0);
        @(negedge aclk) chk(irq, 1);
        bus(0, 5'h14, 32'h0);
        chk(q[1:0], 2'h1);
        @(negedge aclk) chk(irq, 0);
        bus(1, 5'h18, 32'h0);
        ev(5'h03, 12'h200, 1, 0);
        @(negedge aclk) chk(irq, 0);
    endtask
    task off_scn;
        bus(1, 5'h00, 32'hC2);
        u_adc_res_src.send(5'h03, 12'h200);
        repeat (4) @(posedge aclk);
        bus(1, 5'h00, 32'h42);
        bus(0, 5'h00, 32'h0);
        chk(q[5], 0);
        ev(5'h03, 12'h200, 0, 1);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        regs_scn;
        modes_scn;
        enable_scn;
        irq_scn;
        off_scn;
        close_out;
    end
endmodule
